// ### pmsc_core.sv
// Purpose: main power state machine with default loading and rail sequencing
// Assumes: fuse and error inputs are static and in the core clock domain
// Notes: pins (turn-on, standby, watchdog, io supply) are synchronised here
`timescale 1ns/100ps
`default_nettype none
`include "pmsc_regs.svh"

// How it works
// - Select bit set and no turn-on: wait in quick-power-up off state.
// - In quick-power-up off with io supply present, mirror access is granted.
// - Charger disabled in quick off until charger-off bit written in system-on.
// - Power-up event ignored while any trim, fuse or self-check error flag.
// - Defaults copied from fuses into functional registers on power-up.
// - Power up enables sequenced regulators one after another in order.
// - Reset release at its slot enters run; later rails keep powering up.
// - Host access to functional registers granted in run and standby.
// - Successful power up enters run with processor reset driven high.
// - Run and standby setpoints of bucks and linears load from fuses.
// - Seventh buck shares one 5-bit voltage loaded from its fuse.
// - Sync-in, sync-out or spread spectrum fuse forces PWM mode code.
// - Otherwise mode from switching fuse: 0 autoskip, 1 PWM.
// - Buck outside the sequence gets off mode code.
// - Linear enable defaults to 1 if sequenced, else 0.
// - Standby entered when standby pin equals the polarity-selected level.
// - Rails disabled by standby settings are sequenced down on entry.
// - Watchdog reset counts events; limit reached goes fail-safe else hard reset.
// - Power down disables all rails in reverse order, then off or fail-safe.
// - Fail-safe entry sets power-up, watchdog, regulator or thermal cause.
// - Cause bits persist; cleared by write-1 in system-on after power-up.
// - Fail-safe transition without bypass locks if the fail-safe counter equals its limit, else increments it.
// - From low-power off with select set and no event, move to quick off.
// - Bypass fuse set: fail-safe transition always exits to low-power off.
module pmsc_core #(
  parameter int NUM_BUCK = `PMSC_NUM_BUCK,
  parameter int NUM_LINEAR = `PMSC_NUM_LINEAR,
  parameter int SLOT_CYCLES = `PMSC_SLOT_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Pins from the system
  input wire logic turnOnEventPin,
  input wire logic standbyPin,
  input wire logic watchdogInputPin,
  input wire logic ioSupplyPresent,
  // Control bits and internal events
  input wire logic lowPowerOffSelect,
  input wire logic standbyPolaritySelect,
  input wire logic backupCellChargerDisable,
  input wire logic backupCellChargerWrite,
  input wire logic turnOffRequest,
  input wire logic internalWatchdogEvent,
  input wire logic [3:0] failCauseClear,
  input wire pmsc_pkg::pmsc_err_s errorFlags,
  input wire pmsc_pkg::pmsc_fault_s faults,
  input wire pmsc_pkg::pmsc_fuse_s fuse,
  // Regulators and processor
  output logic [pmsc_pkg::NR-1:0] regulatorEnable,
  output logic processorResetOut,
  output pmsc_pkg::pmsc_cfg_s functionalConfig,
  // Status
  output pmsc_pkg::pmsc_state_e machineState,
  output logic [3:0] failCause,
  output logic [3:0] watchdogEventCounter,
  output logic [3:0] failsafeCounter,
  output logic mirrorAccessGrant,
  output logic hostAccessGrant,
  output logic chargerDisableOut
);
  localparam int NR = pmsc_pkg::NR;
  localparam int NB = pmsc_pkg::NB;
  if (NUM_BUCK != pmsc_pkg::NB || NUM_LINEAR != pmsc_pkg::NL || SLOT_CYCLES < 1
      || SLOT_CYCLES > 65535)
  begin : gCheck
    $error("pmsc_core: unsupported parameter values");
  end
  typedef struct packed {
    pmsc_pkg::pmsc_state_e state;
    logic [3:0] syncA;
    logic [3:0] syncB;
    logic wdiLast;
    logic [15:0] slotCnt;
    logic [NR-1:0] regEn;
    logic rstOut;
    logic faultPath;
    logic [3:0] pendCause;
    logic [3:0] failCause;
    logic [3:0] wdCnt;
    logic [3:0] fsCnt;
    logic chgProgrammed;
    logic chgDisable;
    logic mirrorOk;
    logic hostOk;
    pmsc_pkg::pmsc_cfg_s cfg;
  } pmsc_core_s;
  pmsc_core_s st_reg;
  pmsc_core_s st_next;
  // Lowest set bit as a one-hot mask
  function automatic logic [NR-1:0] lowestBit(input logic [NR-1:0] v);
    return v & (~v + NR'(1));
  endfunction
  // Highest set bit as a one-hot mask
  function automatic logic [NR-1:0] highestBit(input logic [NR-1:0] v);
    logic [NR-1:0] r;
    r = '0;
    for (int i = 0; i < NR; i++)
      if (v[i])
        r = NR'(1) << i;
    return r;
  endfunction
  // Default switching mode of one buck
  function automatic logic [1:0] bootMode(input logic member, input pmsc_pkg::pmsc_fuse_s f);
    if (!member)
      return `PMSC_MODE_OFF;
    if (f.clockSyncInputEnable || f.clockSyncOutputEnable || f.spreadSpectrumEnable)
      return `PMSC_MODE_PWM;
    return f.defaultSwitchingMode ? `PMSC_MODE_PWM : `PMSC_MODE_AUTOSKIP;
  endfunction
  logic turnOn;
  logic standbyLevel;
  logic ioPresent;
  logic wdiLevel;
  logic [NR-1:0] target;
  logic slotTick;
  logic watchdogHit;
  logic powerUpAllowed;
  logic systemOn;
  always_comb
  begin
    st_next = st_reg;
    turnOn = st_reg.syncB[0];
    standbyLevel = st_reg.syncB[1];
    ioPresent = st_reg.syncB[2];
    wdiLevel = st_reg.syncB[3];
    // Pins reach logic only through the second stage
    st_next.syncA = {watchdogInputPin, ioSupplyPresent, standbyPin, turnOnEventPin};
    st_next.syncB = st_reg.syncA;
    st_next.wdiLast = wdiLevel;
    systemOn = (st_reg.state == pmsc_pkg::ST_RUN) || (st_reg.state == pmsc_pkg::ST_STANDBY);
    watchdogHit = systemOn && ((wdiLevel != st_reg.wdiLast) || internalWatchdogEvent);
    powerUpAllowed = turnOn && !(errorFlags.trimLoadErrorFlag || errorFlags.fuseLoadErrorFlag
                                 || errorFlags.selfCheckErrorFlag);
    // Sequencer target per state
    case (st_reg.state)
      pmsc_pkg::ST_PWR_UP, pmsc_pkg::ST_RUN: target = fuse.sequenceMember;
      // rails not kept in standby go down
      pmsc_pkg::ST_STANDBY: target = fuse.sequenceMember & fuse.standbyKeep;
      default: target = '0;
    endcase

    // Slot divider: one regulator step per slot
    slotTick = (st_reg.slotCnt == 16'(SLOT_CYCLES - 1));
    st_next.slotCnt = slotTick ? 16'h0000 : st_reg.slotCnt + 16'h0001;
    if (slotTick)
    begin
      if ((target & ~st_reg.regEn) != '0)
        st_next.regEn = st_reg.regEn | lowestBit(target & ~st_reg.regEn);
      else if ((st_reg.regEn & ~target) != '0)
        st_next.regEn = st_reg.regEn & ~highestBit(st_reg.regEn & ~target);
    end

    // clear by write 1 only in system-on, a new cause wins
    if (systemOn)
      st_next.failCause = st_reg.failCause & ~failCauseClear;

    // charger follows the bit once written in system-on
    if (systemOn && backupCellChargerWrite)
    begin
      st_next.chgProgrammed = 1'b1;
      st_next.chgDisable = backupCellChargerDisable;
    end
    if (st_reg.state == pmsc_pkg::ST_QUICK_POWER_UP_OFF_STATE && !st_reg.chgProgrammed)
      st_next.chgDisable = 1'b1;

    case (st_reg.state)
      pmsc_pkg::ST_LOW_POWER_OFF_STATE:
      begin
        st_next.rstOut = 1'b0;
        if (powerUpAllowed)
          st_next.state = pmsc_pkg::ST_PWR_UP;
        else if (lowPowerOffSelect && !turnOn)
          st_next.state = pmsc_pkg::ST_QUICK_POWER_UP_OFF_STATE;
      end
      pmsc_pkg::ST_QUICK_POWER_UP_OFF_STATE:
      begin
        if (powerUpAllowed)
          st_next.state = pmsc_pkg::ST_PWR_UP;
        else if (!lowPowerOffSelect)
          st_next.state = pmsc_pkg::ST_LOW_POWER_OFF_STATE;
      end
      pmsc_pkg::ST_PWR_UP, pmsc_pkg::ST_WD_RESET:
      begin
        if (st_reg.state == pmsc_pkg::ST_WD_RESET)
        begin
          // Hard reset: all rails down first, then a fresh power up
          st_next.rstOut = 1'b0;
          if (st_reg.regEn == '0)
            st_next.state = pmsc_pkg::ST_PWR_UP;
        end
        else if (faults.powerUpFailure || faults.regulatorFailure
                 || faults.thermalShutdown)
        begin
          st_next.state = pmsc_pkg::ST_PWR_DOWN;
          st_next.faultPath = 1'b1;
          st_next.pendCause[`PMSC_CAUSE_PU] = faults.powerUpFailure;
          st_next.pendCause[`PMSC_CAUSE_REG] = faults.regulatorFailure;
          st_next.pendCause[`PMSC_CAUSE_TSD] = faults.thermalShutdown;
        end
        // reset slot reached, or whole sequence done
        else if ((fuse.resetSlot < 4'(NR) && st_reg.regEn[fuse.resetSlot[3:0]])
                 || st_reg.regEn == fuse.sequenceMember)
        begin
          st_next.state = pmsc_pkg::ST_RUN;
          st_next.rstOut = 1'b1;
        end
      end
      pmsc_pkg::ST_RUN, pmsc_pkg::ST_STANDBY:
      begin
        st_next.state = (standbyLevel == standbyPolaritySelect) ? pmsc_pkg::ST_STANDBY
                                                                : pmsc_pkg::ST_RUN;
        if (faults.regulatorFailure || faults.thermalShutdown)
        begin
          st_next.state = pmsc_pkg::ST_PWR_DOWN;
          st_next.faultPath = 1'b1;
          st_next.pendCause[`PMSC_CAUSE_REG] = faults.regulatorFailure;
          st_next.pendCause[`PMSC_CAUSE_TSD] = faults.thermalShutdown;
          st_next.rstOut = 1'b0;
        end
        else if (watchdogHit)
        begin
          st_next.wdCnt = st_reg.wdCnt + 4'h1;
          st_next.rstOut = 1'b0;
          if (st_reg.wdCnt + 4'h1 == fuse.watchdogEventLimit)
          begin
            st_next.state = pmsc_pkg::ST_PWR_DOWN;
            st_next.faultPath = 1'b1;
            st_next.pendCause[`PMSC_CAUSE_WD] = 1'b1;
          end
          else
            st_next.state = pmsc_pkg::ST_WD_RESET;
        end
        else if (turnOffRequest)
        begin
          st_next.state = pmsc_pkg::ST_PWR_DOWN;
          st_next.faultPath = 1'b0;
          st_next.rstOut = 1'b0;
        end
      end
      pmsc_pkg::ST_PWR_DOWN:
      begin
        st_next.rstOut = 1'b0;
        // after the last rail, off or fail-safe
        if (st_reg.regEn == '0)
          st_next.state = st_reg.faultPath ? pmsc_pkg::ST_FS_TRANS : pmsc_pkg::ST_LOW_POWER_OFF_STATE;
      end
      pmsc_pkg::ST_FS_TRANS:
      begin
        st_next.failCause = st_reg.failCause | st_reg.pendCause;
        st_next.pendCause = 4'h0;
        st_next.faultPath = 1'b0;
        if (fuse.failsafeBypass)
          st_next.state = pmsc_pkg::ST_LOW_POWER_OFF_STATE;
        else if (st_reg.fsCnt == fuse.failsafeLimit)
          st_next.state = pmsc_pkg::ST_FS_LOCK;
        else
        begin
          st_next.fsCnt = st_reg.fsCnt + 4'h1;
          st_next.state = pmsc_pkg::ST_LOW_POWER_OFF_STATE;
        end
      end
      pmsc_pkg::ST_FS_LOCK:
        st_next.state = pmsc_pkg::ST_FS_LOCK;
      default:
        st_next.state = pmsc_pkg::ST_LOW_POWER_OFF_STATE;
    endcase
    // defaults loaded on entry to power up
    if (st_next.state == pmsc_pkg::ST_PWR_UP && st_reg.state != pmsc_pkg::ST_PWR_UP)
    begin
      // run and standby from the same fuses
      st_next.cfg.buckRunVoltage = fuse.buckVoltage;
      st_next.cfg.buckStandbyVoltage = fuse.buckVoltage;
      st_next.cfg.linearRunVoltage = fuse.linearVoltage;
      st_next.cfg.linearStandbyVoltage = fuse.linearVoltage;
      st_next.cfg.buckSevenVoltage = fuse.buckSevenVoltage;
      for (int b = 0; b < NB; b++)
      begin
        st_next.cfg.buckRunSwitchingMode[b] = bootMode(fuse.sequenceMember[b], fuse);
        st_next.cfg.buckStandbySwitchingMode[b] = bootMode(fuse.sequenceMember[b], fuse);
      end
      st_next.cfg.linearRunEnable = fuse.sequenceMember[NR-1:NB+1];
    end
    // mirror access in quick off with io supply
    st_next.mirrorOk = (st_next.state == pmsc_pkg::ST_QUICK_POWER_UP_OFF_STATE) && ioPresent;
    st_next.hostOk = (st_next.state == pmsc_pkg::ST_RUN)
                     || (st_next.state == pmsc_pkg::ST_STANDBY);
  end
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_reg <= '0;
      st_reg.state <= pmsc_pkg::ST_LOW_POWER_OFF_STATE;
      st_reg.chgDisable <= 1'b1;
    end
    else
      st_reg <= st_next;
  end
  assign regulatorEnable = st_reg.regEn;
  assign processorResetOut = st_reg.rstOut;
  assign functionalConfig = st_reg.cfg;
  assign machineState = st_reg.state;
  assign failCause = st_reg.failCause;
  assign watchdogEventCounter = st_reg.wdCnt;
  assign failsafeCounter = st_reg.fsCnt;
  assign mirrorAccessGrant = st_reg.mirrorOk;
  assign hostAccessGrant = st_reg.hostOk;
  assign chargerDisableOut = st_reg.chgDisable;
endmodule
`default_nettype wire

// ### pmsc_core_sva.sv
// Purpose: port-level checks of the power state machine core
// Assumes: fuse and error inputs static; pins pass two sync flops
// Notes: bound into every pmsc_core instance
`timescale 1ns/100ps
`default_nettype none
module pmsc_core_sva (
  // Clock, reset and inputs
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic turnOnEventPin,
  input wire logic standbyPin,
  input wire logic lowPowerOffSelect,
  input wire logic standbyPolaritySelect,
  input wire logic turnOffRequest,
  input wire logic [3:0] failCauseClear,
  input wire pmsc_pkg::pmsc_err_s errorFlags,
  input wire pmsc_pkg::pmsc_fault_s faults,
  input wire pmsc_pkg::pmsc_fuse_s fuse,
  // Outputs
  input wire logic [pmsc_pkg::NR-1:0] regulatorEnable,
  input wire logic processorResetOut,
  input wire pmsc_pkg::pmsc_cfg_s functionalConfig,
  input wire pmsc_pkg::pmsc_state_e machineState,
  input wire logic [3:0] failCause,
  input wire logic [3:0] watchdogEventCounter,
  input wire logic hostAccessGrant
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  logic [pmsc_pkg::NB-1:0][1:0] expMode;
  logic syncAny;
  assign syncAny = fuse.clockSyncInputEnable | fuse.clockSyncOutputEnable
    | fuse.spreadSpectrumEnable;
  always_comb
  begin
    for (int i = 0; i < pmsc_pkg::NB; i++)
    begin
      if (!fuse.sequenceMember[i])
        expMode[i] = 2'h0;
      else
        expMode[i] = (syncAny | fuse.defaultSwitchingMode) ? 2'h1 : 2'h3;
    end
  end
  AST_QPU_HOLD: assert property (
    (machineState == pmsc_pkg::ST_QUICK_POWER_UP_OFF_STATE && lowPowerOffSelect && !turnOnEventPin) [*3]
    |=> machineState == pmsc_pkg::ST_QUICK_POWER_UP_OFF_STATE) else $error("quick off left without turn-on");
  AST_LP_TO_QPU: assert property (
    (machineState == pmsc_pkg::ST_LOW_POWER_OFF_STATE && lowPowerOffSelect && !turnOnEventPin) [*3]
    |=> machineState == pmsc_pkg::ST_QUICK_POWER_UP_OFF_STATE) else $error("low-power off did not move on");
  AST_ERR_BLOCK: assert property (
    machineState == pmsc_pkg::ST_QUICK_POWER_UP_OFF_STATE && errorFlags != 3'h0
    |=> machineState != pmsc_pkg::ST_PWR_UP) else $error("power-up taken with error flag");
  AST_VOLT_LOAD: assert property (
    machineState == pmsc_pkg::ST_PWR_UP |-> functionalConfig.buckRunVoltage == fuse.buckVoltage
    && functionalConfig.buckStandbyVoltage == fuse.buckVoltage
    && functionalConfig.linearRunVoltage == fuse.linearVoltage
    && functionalConfig.linearStandbyVoltage == fuse.linearVoltage)
    else $error("setpoints differ from fuse values");
  AST_SW7_LOAD: assert property (
    machineState == pmsc_pkg::ST_PWR_UP
    |-> functionalConfig.buckSevenVoltage == fuse.buckSevenVoltage)
    else $error("seventh buck voltage not loaded");
  AST_MODE_LOAD: assert property (
    machineState == pmsc_pkg::ST_PWR_UP |-> functionalConfig.buckRunSwitchingMode == expMode
    && functionalConfig.buckStandbySwitchingMode == expMode) else $error("wrong mode default");
  AST_LDO_EN: assert property (
    machineState == pmsc_pkg::ST_PWR_UP
    |-> functionalConfig.linearRunEnable == fuse.sequenceMember[pmsc_pkg::NR-1:pmsc_pkg::NB+1])
    else $error("wrong linear enable default");
  AST_RISE_ORDER: assert property (
    machineState == pmsc_pkg::ST_PWR_UP && $past(machineState) == pmsc_pkg::ST_PWR_UP
    && $changed(regulatorEnable) |-> $onehot(regulatorEnable ^ $past(regulatorEnable))
    && (regulatorEnable ^ $past(regulatorEnable)) > $past(regulatorEnable)
    && (regulatorEnable & ~fuse.sequenceMember) == '0) else $error("rail order broken");
  AST_RESET_SLOT: assert property (
    $past(machineState) == pmsc_pkg::ST_PWR_UP && machineState == pmsc_pkg::ST_RUN
    && fuse.resetSlot < 4'ha && fuse.sequenceMember[fuse.resetSlot]
    |-> regulatorEnable[fuse.resetSlot])
    else $error("run entered before reset slot");
  AST_RUN_OUT: assert property (
    machineState == pmsc_pkg::ST_RUN |-> processorResetOut && hostAccessGrant)
    else $error("run without reset release or host access");
  AST_STBY_ENTRY: assert property (
    (machineState == pmsc_pkg::ST_RUN && standbyPin == standbyPolaritySelect
    && !turnOffRequest && faults == 3'h0) [*3] |=> machineState == pmsc_pkg::ST_STANDBY)
    else $error("standby level not honoured");
  AST_WD_COUNT: assert property (
    $changed(watchdogEventCounter)
    |-> watchdogEventCounter == $past(watchdogEventCounter) + 4'h1 ##[0:1] machineState
    == ((watchdogEventCounter == fuse.watchdogEventLimit) ? pmsc_pkg::ST_PWR_DOWN
    : pmsc_pkg::ST_WD_RESET)) else $error("watchdog count or outcome wrong");
  AST_DOWN_FALL: assert property (
    machineState == pmsc_pkg::ST_PWR_DOWN |=> (regulatorEnable & ~$past(regulatorEnable)) == '0
    && (machineState == pmsc_pkg::ST_PWR_DOWN || regulatorEnable == '0))
    else $error("power down raised a rail or left early");
  AST_FS_CAUSE: assert property (
    machineState == pmsc_pkg::ST_FS_TRANS |=> failCause != 4'h0) else $error("no cause bit");
  AST_FS_BYPASS: assert property (
    $past(machineState) == pmsc_pkg::ST_FS_TRANS && fuse.failsafeBypass
    |-> machineState == pmsc_pkg::ST_LOW_POWER_OFF_STATE) else $error("bypass not honoured");
  AST_CAUSE_KEEP: assert property (
    ($past(failCause) & ~failCause & ~$past(failCauseClear)) == 4'h0)
    else $error("cause bit lost without clear");
  cover property (machineState == pmsc_pkg::ST_STANDBY);
  cover property (machineState == pmsc_pkg::ST_FS_TRANS);
  cover property ($changed(watchdogEventCounter));
  cover property (machineState == pmsc_pkg::ST_FS_LOCK);
endmodule
bind pmsc_core pmsc_core_sva chk (.core_clk, .rst_b, .turnOnEventPin, .standbyPin,
  .lowPowerOffSelect, .standbyPolaritySelect, .turnOffRequest, .failCauseClear, .errorFlags,
  .faults, .fuse, .regulatorEnable, .processorResetOut, .functionalConfig, .machineState,
  .failCause, .watchdogEventCounter, .hostAccessGrant);
`default_nettype wire

// ### pmsc_core_test.sv
// Purpose: self-checking bench of the power state machine core
// Assumes: short slot of 4 cycles; inputs change at falling edges
// Notes: fuse rows first, then standby, watchdog, faults and turn-off
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((e) !== (g)) begin n_fail++; \
  $display("ERROR %s exp %h got %h", nm, e, g); end end
module pmsc_core_test;
  typedef struct packed {logic [3:0] ctl; logic [9:0] mem; logic [1:0] mode;} pmsc_row_s;
  pmsc_row_s rows [5] = '{'{4'h0, 10'h3ff, 2'h3}, '{4'h1, 10'h2a5, 2'h1},
    '{4'h8, 10'h0c7, 2'h1}, '{4'h4, 10'h11f, 2'h1}, '{4'h2, 10'h3f4, 2'h1}};
  logic core_clk = 1'b0, rst_b = 1'b0, on = 1'b0, sel = 1'b0, pol = 1'b0, io = 1'b1;
  logic chgDis = 1'b1, chgWr = 1'b0, off = 1'b0, iwd = 1'b0, wantStby = 1'b0, kick = 1'b0;
  logic [3:0] clr = 4'h0;
  pmsc_pkg::pmsc_err_s err = 3'h0;
  pmsc_pkg::pmsc_fault_s flt = 3'h0;
  pmsc_pkg::pmsc_fuse_s fuse = {48'h0a1b2c3d4e5f, 12'h9c3, 5'h15, 10'h3ff, 10'h00f, 4'h2,
    4'h0, 1'b0, 4'h3, 4'h2};
  logic sbPin, wdPin, rstOut, mirr, host, chgOut;
  logic [9:0] regEn;
  logic [3:0] cause, wdCnt, fsCnt;
  pmsc_pkg::pmsc_cfg_s cfg;
  pmsc_pkg::pmsc_state_e st;
  int n_fail = 0, n_checks = 0;
  always #2.5 core_clk = ~core_clk;
  pmsc_core #(.SLOT_CYCLES(4)) dut (.core_clk, .rst_b, .turnOnEventPin(on),
    .standbyPin(sbPin), .watchdogInputPin(wdPin), .ioSupplyPresent(io),
    .lowPowerOffSelect(sel), .standbyPolaritySelect(pol), .backupCellChargerDisable(chgDis),
    .backupCellChargerWrite(chgWr), .turnOffRequest(off), .internalWatchdogEvent(iwd),
    .failCauseClear(clr), .errorFlags(err), .faults(flt), .fuse, .regulatorEnable(regEn),
    .processorResetOut(rstOut), .functionalConfig(cfg), .machineState(st),
    .failCause(cause), .watchdogEventCounter(wdCnt), .failsafeCounter(fsCnt),
    .mirrorAccessGrant(mirr), .hostAccessGrant(host), .chargerDisableOut(chgOut));
  pmsc_host_model cpu (.core_clk, .processorResetOut(rstOut), .standbyPolaritySelect(pol),
    .wantStandby(wantStby), .kick, .standbyPin(sbPin), .watchdogInputPin(wdPin));
  task automatic tally_and_finish();
    if (n_fail == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Rails or state reached within a bound, else the run ends
  task automatic waitFor(input bit rails, input logic [9:0] v);
    repeat (3000)
    begin
      if (rails ? regEn === v : st === v[3:0])
        return;
      @(negedge core_clk);
    end
    n_fail++;
    $display("ERROR wait exp %h got %h %h", v, st, regEn);
    tally_and_finish();
  endtask
  task automatic pulse(input int which);
    {chgWr, kick, iwd} = 3'(which);
    @(negedge core_clk);
    {chgWr, kick, iwd} = 3'h0;
    @(negedge core_clk);
  endtask
  initial
  begin
    repeat (12) @(negedge core_clk);
    `CHK("rstState", pmsc_pkg::ST_LOW_POWER_OFF_STATE, st);
    `CHK("rstOuts", 13'h1000, {chgOut, rstOut, regEn, host});
    for (int r = 0; r < 5; r++)
    begin
      {fuse.clockSyncInputEnable, fuse.clockSyncOutputEnable, fuse.spreadSpectrumEnable,
        fuse.defaultSwitchingMode} = rows[r].ctl;
      fuse.sequenceMember = rows[r].mem;
      pol = ~r[0];
      on = 1'b0;
      rst_b = 1'b0;
      repeat (12) @(negedge core_clk);
      rst_b = 1'b1;
      sel = 1'b1;
      waitFor(0, pmsc_pkg::ST_QUICK_POWER_UP_OFF_STATE);
      `CHK("chgQpu", 1'b1, chgOut);
      on = 1'b1;
      waitFor(0, pmsc_pkg::ST_PWR_UP);
      for (int i = 0; i < 6; i++)
      begin
        `CHK("runMode", rows[r].mem[i] ? rows[r].mode : 2'h0, cfg.buckRunSwitchingMode[i]);
        `CHK("stbyMode", rows[r].mem[i] ? rows[r].mode : 2'h0, cfg.buckStandbySwitchingMode[i]);
        `CHK("stbyV", fuse.buckVoltage[i], cfg.buckStandbyVoltage[i]);
      end
      `CHK("ldoEn", rows[r].mem[9:7], cfg.linearRunEnable);
      `CHK("ldoV", fuse.linearVoltage, cfg.linearStandbyVoltage);
      `CHK("sw7V", fuse.buckSevenVoltage, cfg.buckSevenVoltage);
      waitFor(0, pmsc_pkg::ST_RUN);
      `CHK("rstOut", 1'b1, rstOut);
      `CHK("railsLeft", 1'b1, regEn != rows[r].mem);
      waitFor(1, rows[r].mem);
      `CHK("host", 1'b1, host);
    end
    wantStby = 1'b1;
    waitFor(0, pmsc_pkg::ST_STANDBY);
    waitFor(1, 10'h004);
    wantStby = 1'b0;
    waitFor(0, pmsc_pkg::ST_RUN);
    chgDis = 1'b0;
    pulse(4);
    pulse(2);
    waitFor(0, pmsc_pkg::ST_WD_RESET);
    `CHK("wdCnt", 4'h1, wdCnt);
    waitFor(0, pmsc_pkg::ST_RUN);
    on = 1'b0;
    pulse(1);
    waitFor(0, pmsc_pkg::ST_FS_TRANS);
    waitFor(0, pmsc_pkg::ST_QUICK_POWER_UP_OFF_STATE);
    `CHK("wdCause", 4'h2, cause);
    `CHK("fsCnt", 4'h1, fsCnt);
    `CHK("railsOff", 10'h0, regEn);
    `CHK("chgFollow", 1'b0, chgOut);
    `CHK("mirror", 1'b1, mirr);
    err = 3'h2;
    on = 1'b1;
    repeat (20) @(negedge core_clk);
    `CHK("errHold", pmsc_pkg::ST_QUICK_POWER_UP_OFF_STATE, st);
    io = 1'b0;
    repeat (4) @(negedge core_clk);
    `CHK("mirrorOff", 1'b0, mirr);
    io = 1'b1;
    err = 3'h0;
    waitFor(0, pmsc_pkg::ST_RUN);
    `CHK("causeKept", 4'h2, cause);
    clr = 4'h2;
    @(negedge core_clk);
    clr = 4'h0;
    `CHK("cleared", 4'h0, cause);
    {fuse.failsafeBypass, fuse.failsafeLimit} = 5'h11;
    {on, sel} = 2'h0;
    flt = 3'h2;
    waitFor(0, pmsc_pkg::ST_FS_TRANS);
    waitFor(0, pmsc_pkg::ST_LOW_POWER_OFF_STATE);
    flt = 3'h0;
    `CHK("regCause", 4'h4, cause);
    on = 1'b1;
    waitFor(0, pmsc_pkg::ST_RUN);
    {on, off} = 2'h1;
    waitFor(0, pmsc_pkg::ST_PWR_DOWN);
    waitFor(0, pmsc_pkg::ST_LOW_POWER_OFF_STATE);
    off = 1'b0;
    repeat (8) @(negedge core_clk);
    `CHK("offStay", pmsc_pkg::ST_LOW_POWER_OFF_STATE, st);
    `CHK("offCause", 4'h4, cause);
    // Power-up failure with the counter at its limit locks the machine
    flt = 3'h4;
    {fuse.failsafeBypass, on} = 2'h1;
    waitFor(0, pmsc_pkg::ST_FS_LOCK);
    `CHK("puCause", 4'h5, cause);
    `CHK("fsHold", 4'h1, fsCnt);
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ### pmsc_host_model.sv
// Purpose: processor side of the core's control pins
// Assumes: acts only while out of reset
// Notes: pins change just after a rising edge
`timescale 1ns/100ps
`default_nettype none
module pmsc_host_model (
  // Clock and processor reset
  input wire logic core_clk,
  input wire logic processorResetOut,
  // Bench commands
  input wire logic standbyPolaritySelect,
  input wire logic wantStandby,
  input wire logic kick,
  // Pins towards the core
  output logic standbyPin,
  output logic watchdogInputPin
);
  initial watchdogInputPin = 1'b0;
  always @(posedge core_clk)
  begin
    standbyPin <= (wantStandby & processorResetOut) ? standbyPolaritySelect
      : ~standbyPolaritySelect;
    // A kick in reset would be lost by a real processor too
    if (kick && processorResetOut)
      watchdogInputPin <= ~watchdogInputPin;
  end
endmodule
`default_nettype wire

// ### pmsc_pkg.sv
// Purpose: types of the power state machine core
// Assumes: pmsc_regs.svh sizes
// Notes: widths fixed here; the core checks its parameters against them
`default_nettype none
`include "pmsc_regs.svh"
package pmsc_pkg;
  localparam int NB = `PMSC_NUM_BUCK;
  localparam int NL = `PMSC_NUM_LINEAR;
  localparam int NR = NB + 1 + NL;

  typedef enum logic [3:0] {
    ST_LOW_POWER_OFF_STATE, ST_QUICK_POWER_UP_OFF_STATE, ST_PWR_UP, ST_RUN, ST_STANDBY,
    ST_WD_RESET, ST_PWR_DOWN, ST_FS_TRANS, ST_FS_LOCK
  } pmsc_state_e;

  typedef struct packed {
    logic [NB-1:0][7:0] buckVoltage;
    logic [NL-1:0][3:0] linearVoltage;
    logic [4:0] buckSevenVoltage;
    logic [NR-1:0] sequenceMember;
    logic [NR-1:0] standbyKeep;
    logic [3:0] resetSlot;
    logic clockSyncInputEnable;
    logic clockSyncOutputEnable;
    logic spreadSpectrumEnable;
    logic defaultSwitchingMode;
    logic failsafeBypass;
    logic [3:0] failsafeLimit;
    logic [3:0] watchdogEventLimit;
  } pmsc_fuse_s;

  typedef struct packed {
    logic [NB-1:0][7:0] buckRunVoltage;
    logic [NB-1:0][7:0] buckStandbyVoltage;
    logic [NL-1:0][3:0] linearRunVoltage;
    logic [NL-1:0][3:0] linearStandbyVoltage;
    logic [4:0] buckSevenVoltage;
    logic [NB-1:0][1:0] buckRunSwitchingMode;
    logic [NB-1:0][1:0] buckStandbySwitchingMode;
    logic [NL-1:0] linearRunEnable;
  } pmsc_cfg_s;

  typedef struct packed {
    logic trimLoadErrorFlag;
    logic fuseLoadErrorFlag;
    logic selfCheckErrorFlag;
  } pmsc_err_s;

  typedef struct packed {
    logic powerUpFailure;
    logic regulatorFailure;
    logic thermalShutdown;
  } pmsc_fault_s;
endpackage
`default_nettype wire

// ### pmsc_regs.svh
// Purpose: shared constants for the power state machine core
// Assumes: core clock period is given in nanoseconds
// Notes: definitions only
`ifndef PMSC_REGS_SVH
`define PMSC_REGS_SVH

`define PMSC_NUM_BUCK 6
`define PMSC_NUM_LINEAR 3
`define PMSC_CLK_PERIOD_NS 5
// Sequencer slot length, shortest spacing between two regulator steps
`define PMSC_SLOT_TIME_NS 2000
`define PMSC_SLOT_CYCLES ((`PMSC_SLOT_TIME_NS + `PMSC_CLK_PERIOD_NS - 1) / `PMSC_CLK_PERIOD_NS)

// Switching mode codes
`define PMSC_MODE_OFF 2'h0
`define PMSC_MODE_PWM 2'h1
`define PMSC_MODE_AUTOSKIP 2'h3

// Cause bit positions
`define PMSC_CAUSE_PU 0
`define PMSC_CAUSE_WD 1
`define PMSC_CAUSE_REG 2
`define PMSC_CAUSE_TSD 3

`endif
